// ==== rtl/arft_core.sv ====
/*
 Auto-retry transmit sequencer with AXI4-Lite registers.
 Assumes a backoff/CCA engine, transmitter and receiver outside,
 all synchronous to aclk, giving one-cycle pulses.
*/
module arft_core #(
    parameter int ACK_TO = arft_pkg::ACK_TO_CYC
) (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Host strobe
    input  wire logic               sleep_transmit_strobe,
    // Channel access engine
    output logic                    csma_req,
    input  wire logic               csma_done,
    input  wire logic               csma_clear,
    input  wire logic               channel_check_done_event,
    // Transmitter
    output logic                    tx_go,
    input  wire logic               tx_done,
    input  wire logic [7:0]         psdu_octet1,
    output logic                    timestamp_output_pin,
    output logic                    fb_lock,
    // Receiver
    output logic                    rx_on,
    input  wire arft_pkg::arft_ack_t ack,
    input  wire arft_pkg::arft_rx_t  rx,
    // Gated events
    output logic [7:0]              irq
);
    arft_pkg::arft_state_t st_q;     // Sequencer state
    logic [2:0]  res_q;              // Transaction result
    logic [2:0]  csma_q;             // Channel retry counter
    logic [4:0]  frm_q;              // Frame retry counter
    logic [14:0] tmr_q;              // Ack wait timer
    logic [7:0]  ctrl1_q;            // Control one
    logic [7:0]  mask_q;             // Event mask
    logic [7:0]  auto1_q;            // Auto-mode control one
    logic [7:0]  limit_q;            // Retry limits
    logic        strobe_q;           // Strobe history
    logic        fin_q;              // Transaction finished pulse
    logic        pll_q;              // Lock event pulse
    logic        aw_q, w_q;          // Write halves held
    logic [5:0]  awi_q;              // Held write index
    logic [31:0] wd_q;               // Held write data
    logic        ws_q;               // Held lane 0 strobe
    logic        csma_q_r, txgo_q, ts_q, rxon_q, fbl_q;
    logic [7:0]  irq_q;
    logic        awr_q, wr_q, bv_q, arr_q, rv_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rd_q;

    // Output wiring
    assign s_axi_awready = awr_q;
    assign s_axi_wready  = wr_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rd_q;
    assign csma_req      = csma_q_r;
    assign tx_go         = txgo_q;
    assign timestamp_output_pin = ts_q;
    assign rx_on         = rxon_q;
    assign fb_lock       = fbl_q;
    assign irq           = irq_q;

    // Register decode
    wire wr_go  = aw_q & w_q & ~bv_q;
    wire wr_hit = (awi_q == arft_pkg::IDX_STATE) |
                  (awi_q == arft_pkg::IDX_CTRL1) |
                  (awi_q == arft_pkg::IDX_MASK)  |
                  (awi_q == arft_pkg::IDX_AUTO1) |
                  (awi_q == arft_pkg::IDX_LIMIT);
    wire wr_en  = wr_go & ws_q;
    wire [5:0] ari = s_axi_araddr[7:2];
    wire cmd_wr = wr_en & (awi_q == arft_pkg::IDX_STATE);
    wire [4:0] cmd = wd_q[4:0];

    // Sequencer decode
    wire busy = (st_q == arft_pkg::ST_CSMA) | (st_q == arft_pkg::ST_CSMA_W)
              | (st_q == arft_pkg::ST_TX) | (st_q == arft_pkg::ST_ACK);
    wire strobe_rise = sleep_transmit_strobe & ~strobe_q;
    wire start = (st_q == arft_pkg::ST_IDLE) &
                 (strobe_rise | (cmd_wr & (cmd == arft_pkg::CMD_START)));
    wire [2:0] max_csma = limit_q[arft_pkg::CSMA_LSB +: 3];
    wire [4:0] max_frm  = {1'b0, limit_q[arft_pkg::FRM_LSB +: 4]};
    wire no_csma = (max_csma == arft_pkg::NO_CSMA);
    wire [2:0] csma_inc = csma_q + 3'h1;
    wire ack_req = psdu_octet1[arft_pkg::ACK_BIT];
    wire ack_ok = ack.valid & ack.seq_ok & ack.fcs_ok;
    wire ts_ok = ctrl1_q[arft_pkg::EXT_BIT] &
                 auto1_q[arft_pkg::TS_BIT];
    wire to_hit = (tmr_q == 15'(ACK_TO - 1));
    wire aack = (st_q == arft_pkg::ST_AACK);
    wire [4:0] sts = busy ? arft_pkg::STS_BUSY :
                     (st_q == arft_pkg::ST_IDLE) ? arft_pkg::STS_IDLE :
                     aack ? arft_pkg::STS_AACK : arft_pkg::STS_OFF;

    // Raw events; busy hides channel checks, rx events are raised only in auto-ack state
    logic [7:0] irq_raw;
    always_comb begin
        irq_raw = 8'h00;
        irq_raw[arft_pkg::IRQ_PLL] = pll_q;
        irq_raw[arft_pkg::IRQ_END] = fin_q |
            (aack & rx.done & rx.filt_ok & rx.fcs_ok);
        irq_raw[arft_pkg::IRQ_RXS] = aack & rx.phr;
        irq_raw[arft_pkg::IRQ_AMI] = aack & rx.amatch;
        irq_raw[arft_pkg::IRQ_CCA] = channel_check_done_event & ~busy;
    end

    // Read mux; unmapped words read zero with an error response
    logic [7:0] rmux;
    logic       rhit;
    always_comb begin
        rhit = 1'b1;
        case (ari)
            arft_pkg::IDX_STATUS: rmux = {3'h0, sts};
            arft_pkg::IDX_STATE:  rmux = {res_q, 5'h00};
            arft_pkg::IDX_CTRL1:  rmux = ctrl1_q;
            arft_pkg::IDX_MASK:   rmux = mask_q;
            arft_pkg::IDX_AUTO1:  rmux = auto1_q;
            arft_pkg::IDX_RETRY:  rmux = {frm_q[3:0], csma_q, 1'b0};
            arft_pkg::IDX_LIMIT:  rmux = limit_q;
            default: begin
                rmux = 8'h00;
                rhit = 1'b0;
            end
        endcase
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q  <= 1'b0;
            w_q   <= 1'b0;
            awr_q <= 1'b1;
            wr_q  <= 1'b1;
            bv_q  <= 1'b0;
            bresp_q <= 2'h0;
            awi_q <= 6'h00;
            wd_q  <= 32'h0000_0000;
            ws_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid & awr_q) begin
                aw_q  <= 1'b1;
                awr_q <= 1'b0;
                awi_q <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid & wr_q) begin
                w_q  <= 1'b1;
                wr_q <= 1'b0;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q  <= 1'b0;
                bv_q <= 1'b1;
                bresp_q <= wr_hit ? 2'h0 : 2'h2;
            end
            // Ready returns only once the response is taken
            if (bv_q & s_axi_bready) begin
                bv_q  <= 1'b0;
                awr_q <= 1'b1;
                wr_q  <= 1'b1;
            end
        end
    end

    // Read channel: one-cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arr_q <= 1'b1;
            rv_q  <= 1'b0;
            rd_q  <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else if (s_axi_arvalid & arr_q) begin
            arr_q <= 1'b0;
            rv_q  <= 1'b1;
            rd_q  <= {24'h000000, rmux};
            rresp_q <= rhit ? 2'h0 : 2'h2;
        end else if (rv_q & s_axi_rready) begin
            arr_q <= 1'b1;
            rv_q  <= 1'b0;
        end
    end

    // Control registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl1_q <= arft_pkg::RST_ZERO;
            mask_q  <= arft_pkg::RST_ZERO;
            auto1_q <= arft_pkg::RST_ZERO;
            limit_q <= arft_pkg::RST_LIMIT;
        end else if (wr_en) begin
            if (awi_q == arft_pkg::IDX_CTRL1) ctrl1_q <= wd_q[7:0];
            if (awi_q == arft_pkg::IDX_MASK)  mask_q  <= wd_q[7:0];
            if (awi_q == arft_pkg::IDX_AUTO1) auto1_q <= wd_q[7:0];
            if (awi_q == arft_pkg::IDX_LIMIT) limit_q <= wd_q[7:0];
        end
    end

    // Masked events, one cycle after their cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q    <= 8'h00;
            strobe_q <= 1'b0;
            fbl_q    <= 1'b0;
        end else begin
            irq_q    <= irq_raw & mask_q;
            strobe_q <= sleep_transmit_strobe;
            fbl_q    <= busy;
        end
    end

    // Transaction sequencer; commands ignored while busy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q   <= arft_pkg::ST_OFF;
            res_q  <= arft_pkg::RES_OK;
            csma_q <= 3'h0;
            frm_q  <= 5'h00;
            tmr_q  <= 15'h0000;
            fin_q  <= 1'b0;
            pll_q  <= 1'b0;
            csma_q_r <= 1'b0;
            txgo_q <= 1'b0;
            ts_q   <= 1'b0;
            rxon_q <= 1'b0;
        end else begin
            fin_q    <= 1'b0;
            pll_q    <= 1'b0;
            csma_q_r <= 1'b0;
            txgo_q   <= 1'b0;
            ts_q     <= 1'b0;
            case (st_q)
                arft_pkg::ST_OFF: begin
                    if (cmd_wr & (cmd == arft_pkg::CMD_ARET)) begin
                        st_q  <= arft_pkg::ST_IDLE;
                        pll_q <= 1'b1;
                    end else if (cmd_wr & (cmd == arft_pkg::CMD_AACK)) begin
                        st_q  <= arft_pkg::ST_AACK;
                        pll_q <= 1'b1;
                        res_q <= arft_pkg::RES_INV;
                    end
                end
                arft_pkg::ST_IDLE: begin
                    if (start) begin
                        st_q   <= arft_pkg::ST_CSMA;
                        res_q  <= arft_pkg::RES_INV;
                        csma_q <= 3'h0;
                        frm_q  <= 5'h00;
                    end else if (cmd_wr & (cmd == arft_pkg::CMD_OFF)) begin
                        st_q <= arft_pkg::ST_OFF;
                    end
                end
                arft_pkg::ST_AACK: begin
                    if (cmd_wr & (cmd == arft_pkg::CMD_OFF))
                        st_q <= arft_pkg::ST_OFF;
                end
                arft_pkg::ST_CSMA: begin
                    // Limit seven skips channel access altogether
                    if (no_csma) begin
                        st_q   <= arft_pkg::ST_TX;
                        txgo_q <= 1'b1;
                        ts_q   <= ts_ok;
                    end else begin
                        st_q     <= arft_pkg::ST_CSMA_W;
                        csma_q_r <= 1'b1;
                    end
                end
                arft_pkg::ST_CSMA_W: begin
                    if (csma_done & csma_clear) begin
                        st_q   <= arft_pkg::ST_TX;
                        txgo_q <= 1'b1;
                        ts_q   <= ts_ok;
                    end else if (csma_done) begin
                        csma_q <= csma_inc;
                        if (csma_inc > max_csma) begin
                            st_q  <= arft_pkg::ST_IDLE;
                            res_q <= arft_pkg::RES_CAF;
                            fin_q <= 1'b1;
                        end else begin
                            st_q <= arft_pkg::ST_CSMA;
                        end
                    end
                end
                arft_pkg::ST_TX: begin
                    if (tx_done) begin
                        frm_q <= frm_q + 5'h01;
                        if (ack_req) begin
                            st_q   <= arft_pkg::ST_ACK;
                            tmr_q  <= 15'h0000;
                            rxon_q <= 1'b1;
                        end else begin
                            st_q  <= arft_pkg::ST_IDLE;
                            res_q <= arft_pkg::RES_OK;
                            fin_q <= 1'b1;
                        end
                    end
                end
                arft_pkg::ST_ACK: begin
                    // Non-matching frames fall through unseen
                    tmr_q <= tmr_q + 15'h0001;
                    if (ack_ok) begin
                        st_q   <= arft_pkg::ST_IDLE;
                        rxon_q <= 1'b0;
                        res_q  <= ack.pending ? arft_pkg::RES_PEND
                                              : arft_pkg::RES_OK;
                        fin_q  <= 1'b1;
                    end else if (to_hit) begin
                        rxon_q <= 1'b0;
                        if (no_csma | (frm_q > max_frm)) begin
                            st_q  <= arft_pkg::ST_IDLE;
                            res_q <= arft_pkg::RES_NOACK;
                            fin_q <= 1'b1;
                        end else begin
                            st_q   <= arft_pkg::ST_CSMA;
                            csma_q <= 3'h0;
                        end
                    end
                end
                default: st_q <= arft_pkg::ST_OFF;
            endcase
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    start_invalid_a: assert property (start |=>
        res_q == arft_pkg::RES_INV && csma_q == 3'h0 && frm_q == 5'h00)
        else $error("start did not clear result and counters");
    busy_status_a: assert property ($fell(busy) |->
        fin_q && sts == arft_pkg::STS_IDLE)
        else $error("status did not return to idle");
    caf_end_a: assert property (st_q == arft_pkg::ST_CSMA_W &&
        csma_done && !csma_clear && csma_inc > max_csma
        |=> res_q == arft_pkg::RES_CAF && fin_q && irq_raw[arft_pkg::IRQ_END])
        else $error("access failure not reported");
    noack_ok_a: assert property (st_q == arft_pkg::ST_TX &&
        tx_done && !ack_req |=> res_q == arft_pkg::RES_OK && fin_q)
        else $error("no-ack frame not ended with success");
    ack_result_a: assert property (st_q == arft_pkg::ST_ACK &&
        ack_ok |=> res_q == {2'b00, $past(ack.pending)} && !rxon_q)
        else $error("ack result wrong");
    direct_send_a: assert property (st_q == arft_pkg::ST_CSMA &&
        no_csma |=> txgo_q && !csma_q_r)
        else $error("limit seven did not send at once");
    end_irq_a: assert property (fin_q && mask_q[3] |=> irq_q[3])
        else $error("end event lost");
    ack_silent_a: assert property ($past(busy) |->
        !irq_q[arft_pkg::IRQ_RXS] && !irq_q[arft_pkg::IRQ_AMI]
        && !irq_q[arft_pkg::IRQ_CCA])
        else $error("suppressed event raised");
    stamp_gate_a: assert property (ts_q |-> txgo_q && ts_ok)
        else $error("stamp without enables");
    timeout_retry_a: assert property (st_q == arft_pkg::ST_ACK &&
        to_hit && !ack_ok && !no_csma && frm_q <= max_frm
        |=> st_q == arft_pkg::ST_CSMA ##1 csma_q_r)
        else $error("timeout did not retry");
endmodule

// ==== rtl/arft_pkg.sv ====
/*
 Constants, types and register map of the auto-retry frame transmit
 sequencer. Assumes a 25 MHz clock and a 32-bit AXI4-Lite host.
*/
package arft_pkg;
    // Register indices; byte address is index times four
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_STATE  = 6'h02;
    localparam logic [5:0] IDX_CTRL1  = 6'h04;
    localparam logic [5:0] IDX_MASK   = 6'h0E;
    localparam logic [5:0] IDX_AUTO1  = 6'h17;
    localparam logic [5:0] IDX_RETRY  = 6'h19;
    localparam logic [5:0] IDX_LIMIT  = 6'h2C;
    // Reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_LIMIT  = 8'h38;
    // State status codes
    localparam logic [4:0] STS_OFF    = 5'h08;
    localparam logic [4:0] STS_BUSY   = 5'h12;
    localparam logic [4:0] STS_AACK   = 5'h16;
    localparam logic [4:0] STS_IDLE   = 5'h19;
    // State commands
    localparam logic [4:0] CMD_START  = 5'h02;
    localparam logic [4:0] CMD_OFF    = 5'h08;
    localparam logic [4:0] CMD_AACK   = 5'h16;
    localparam logic [4:0] CMD_ARET   = 5'h19;
    // Transaction result codes
    localparam logic [2:0] RES_OK     = 3'h0;
    localparam logic [2:0] RES_PEND   = 3'h1;
    localparam logic [2:0] RES_CAF    = 3'h3;
    localparam logic [2:0] RES_NOACK  = 3'h5;
    localparam logic [2:0] RES_INV    = 3'h7;
    // Field positions
    localparam int IRQ_PLL   = 0;
    localparam int IRQ_RXS   = 2;
    localparam int IRQ_END   = 3;
    localparam int IRQ_CCA   = 4;
    localparam int IRQ_AMI   = 5;
    localparam int ACK_BIT   = 5;
    localparam int EXT_BIT   = 6;
    localparam int TS_BIT    = 3;
    localparam int FRM_LSB   = 4;
    localparam int CSMA_LSB  = 1;
    localparam logic [2:0] NO_CSMA = 3'h7;
    // Ack timeout
    localparam int CLK_NS    = 40;
    localparam int ACK_TO_NS = 864000;
    localparam int ACK_TO_CYC = ACK_TO_NS / CLK_NS;
    // Ack reception result from the receiver
    typedef struct packed {
        logic valid;
        logic seq_ok;
        logic fcs_ok;
        logic pending;
    } arft_ack_t;
    // Auto-ack receive events
    typedef struct packed {
        logic phr;
        logic amatch;
        logic done;
        logic filt_ok;
        logic fcs_ok;
    } arft_rx_t;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF, ST_IDLE, ST_CSMA, ST_CSMA_W, ST_TX, ST_ACK, ST_AACK
    } arft_state_t;
endpackage

// ==== testbench/arft_far.sv ====
/*
 Far-side model: channel access engine, transmitter and ack receiver.
 Assumes one-cycle request pulses from the sequencer on aclk.
*/
module arft_far (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Scenario controls
    input  wire logic        busy,
    input  wire logic [7:0]  frame,
    input  wire logic        give,
    input  wire logic        pend,
    // Sequencer side
    input  wire logic        csma_req,
    input  wire logic        tx_go,
    input  wire logic        rx_on,
    output logic             csma_done,
    output logic             csma_clear,
    output logic             tx_done,
    output logic [7:0]       psdu_octet1,
    output arft_pkg::arft_ack_t ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cs_q; // Attempt delay line
    logic [7:0] tx_q; // Air time of the frame
    logic [3:0] rx_q; // Cycles spent listening
    // Fixed latencies keep expectations simple
    always_ff @(posedge aclk) begin
        cs_q <= aresetn ? {cs_q[1:0], csma_req} : 3'h0;
        tx_q <= aresetn ? {tx_q[6:0], tx_go} : 8'h00;
        rx_q <= (aresetn && rx_on) ? rx_q + 4'h1 : 4'h0;
    end
    assign csma_done = cs_q[2];
    // Outside done the clear line shows the wrong level
    assign csma_clear = csma_done ? !busy : busy;
    assign tx_done = tx_q[7];
    // Octet only valid with done, garbled otherwise
    assign psdu_octet1 = tx_done ? frame : ~frame;
    // Good ack on the fifth listening cycle
    assign ack = {give && rx_q == 4'h4, 1'b1, 1'b1, pend};
endmodule

// ==== testbench/auto_retry_frame_transmit_test.sv ====
/*
 Register-level bench of the auto-retry sequencer.
 Assumes arft_far on the radio side and a short ack timeout.
*/
module auto_retry_frame_transmit_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench-driven inputs
    logic aclk = 1'b0, aresetn = 1'b0, sleep_transmit_strobe = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    // Response readies stay high, so no task toggles them
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic busy = 1'b0, give = 1'b0, pend = 1'b0;
    // Receive and channel-check event pulse, receive checksum result
    logic ev = 1'b0, fcs = 1'b0;
    logic [7:0] frame = 8'h00;
    // Design and far-model outputs, read-back values
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, csma_req, csma_done, csma_clear, tx_go, tx_done;
    logic timestamp_output_pin, fb_lock, rx_on;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata;
    logic [7:0] psdu_octet1, irq, rd;
    arft_pkg::arft_ack_t ack;
    int failures = 0, checks = 0, tx_n = 0, cs_n = 0, end_n = 0;
    int ts_n = 0, lk_n = 0, ev_n = 0;
    arft_core #(.ACK_TO(20)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sleep_transmit_strobe, .csma_req, .csma_done, .csma_clear,
        .channel_check_done_event(ev), .tx_go, .tx_done, .psdu_octet1,
        .timestamp_output_pin, .fb_lock, .rx_on, .ack,
        .rx({ev, ev, ev, ev, fcs}), .irq);
    arft_far u_far (.aclk, .aresetn, .busy, .frame, .give, .pend,
        .csma_req, .tx_go, .rx_on, .csma_done, .csma_clear, .tx_done,
        .psdu_octet1, .ack);
    initial forever #20 aclk = ~aclk;
    // Pulse counters on the radio and event side
    always @(posedge aclk) begin
        if (tx_go) tx_n <= tx_n + 1;
        if (csma_req) cs_n <= cs_n + 1;
        if (timestamp_output_pin) ts_n <= ts_n + 1;
        if (irq[arft_pkg::IRQ_END]) end_n <= end_n + 1;
        if (irq[arft_pkg::IRQ_PLL]) lk_n <= lk_n + 1;
        ev_n <= ev_n + irq[arft_pkg::IRQ_RXS] + irq[arft_pkg::IRQ_AMI]
            + irq[arft_pkg::IRQ_CCA];
    end
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic timeout();
        failures++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        complete_run();
    endtask
    // One write, both halves offered together
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        int n;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) timeout();
    endtask
    task automatic rd_reg(input logic [5:0] idx);
        int n;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata[7:0];
        rs = s_axi_rresp;
        if (n == 40) timeout();
    endtask
    // One transaction: start, watch busy, await idle, check outcome
    task automatic run(input logic strobe, input logic [2:0] res,
                       input logic [7:0] tx, cs, ends, ts);
        int t0, c0, e0, s0, v0, n;
        t0 = tx_n; c0 = cs_n; e0 = end_n; s0 = ts_n;
        v0 = ev_n;
        if (strobe) begin
            sleep_transmit_strobe <= 1'b1;
            @(posedge aclk);
        end else
            wr(arft_pkg::IDX_STATE, {3'h0, arft_pkg::CMD_START});
        sleep_transmit_strobe <= 1'b0;
        rd_reg(arft_pkg::IDX_STATUS);
        chk(rd, {3'h0, arft_pkg::STS_BUSY});
        chk({7'h00, fb_lock}, 8'h01);
        // Events and a fresh strobe edge while busy must stay unseen
        ev <= 1'b1;
        sleep_transmit_strobe <= 1'b1;
        @(posedge aclk);
        ev <= 1'b0;
        sleep_transmit_strobe <= 1'b0;
        rd_reg(arft_pkg::IDX_STATE);
        chk({5'h00, rd[7:5]}, {5'h00, arft_pkg::RES_INV});
        for (n = 0; n < 200; n++) begin
            rd_reg(arft_pkg::IDX_STATUS);
            if (rd[4:0] === arft_pkg::STS_IDLE) break;
        end
        if (n == 200) timeout();
        repeat (2) @(posedge aclk);
        rd_reg(arft_pkg::IDX_STATE);
        chk({5'h00, rd[7:5]}, {5'h00, res});
        chk(8'(tx_n - t0), tx);
        chk(8'(cs_n - c0), cs);
        chk(8'(end_n - e0), ends);
        chk(8'(ts_n - s0), ts);
        chk(8'(ev_n - v0), 8'h00);
        // Frame counter ends equal to the number of sends
        rd_reg(arft_pkg::IDX_RETRY);
        chk({4'h0, rd[7:4]}, tx);
        $display("test done, result %h", res);
    endtask
    // One receive event in auto-ack mode, checksum good or bad
    task automatic aack_ev(input logic good, input logic [7:0] ends);
        int e0, v0;
        e0 = end_n;
        v0 = ev_n;
        fcs <= good;
        ev <= 1'b1;
        @(posedge aclk);
        ev <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(8'(ev_n - v0), 8'h03);
        chk(8'(end_n - e0), ends);
        $display("test done, auto-ack event");
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(arft_pkg::IDX_LIMIT);
        chk(rd, arft_pkg::RST_LIMIT);
        rd_reg(arft_pkg::IDX_STATUS);
        chk(rd, {3'h0, arft_pkg::STS_OFF});
        rd_reg(6'h3F);
        chk({6'h00, rs}, 8'h02);
        $display("test done, reset values");
        wr(arft_pkg::IDX_MASK, 8'hFF);
        wr(arft_pkg::IDX_STATE, {3'h0, arft_pkg::CMD_ARET});
        repeat (2) @(posedge aclk);
        chk(8'(lk_n), 8'h01);
        run(1'b1, arft_pkg::RES_OK, 8'h01, 8'h01, 8'h01, 8'h00);
        frame <= 8'h20;
        give <= 1'b1;
        pend <= 1'b1;
        run(1'b0, arft_pkg::RES_PEND, 8'h01, 8'h01, 8'h01, 8'h00);
        pend <= 1'b0;
        wr(arft_pkg::IDX_CTRL1, 8'h40);
        wr(arft_pkg::IDX_AUTO1, 8'h08);
        run(1'b0, arft_pkg::RES_OK, 8'h01, 8'h01, 8'h01, 8'h01);
        give <= 1'b0;
        wr(arft_pkg::IDX_LIMIT, 8'h18);
        run(1'b0, arft_pkg::RES_NOACK, 8'h02, 8'h02, 8'h01, 8'h02);
        busy <= 1'b1;
        run(1'b0, arft_pkg::RES_CAF, 8'h00, 8'h05, 8'h01, 8'h00);
        wr(arft_pkg::IDX_LIMIT, 8'h1E);
        run(1'b0, arft_pkg::RES_NOACK, 8'h01, 8'h00, 8'h01, 8'h01);
        wr(arft_pkg::IDX_MASK, 8'h00);
        busy <= 1'b0;
        run(1'b1, arft_pkg::RES_NOACK, 8'h01, 8'h00, 8'h00, 8'h01);
        // Off, then auto-ack mode: lock event, invalid result, rx events
        wr(arft_pkg::IDX_MASK, 8'hFF);
        wr(arft_pkg::IDX_STATE, {3'h0, arft_pkg::CMD_OFF});
        wr(arft_pkg::IDX_STATE, {3'h0, arft_pkg::CMD_AACK});
        rd_reg(arft_pkg::IDX_STATE);
        chk({5'h00, rd[7:5]}, {5'h00, arft_pkg::RES_INV});
        chk(8'(lk_n), 8'h02);
        aack_ev(1'b0, 8'h00);
        aack_ev(1'b1, 8'h01);
        complete_run();
    end
endmodule
